// File: rtl/tsp_timer8.sv
// Top of the 8-bit timer/counter with prescaler shared with the watchdog
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Readable, writable 8-bit counter register
// - Clock source clear counts instruction cycles
// - Counter write inhibits two instruction cycles
// - Clock source set counts external pin
// - Edge select chooses rising or falling
// - FFh to 00h wrap sets overflow flag
// - Overflow enable masks interrupt, flag records
// - Hardware never clears overflow flag
// - Counter halted during sleep
// - Unassigned prescaler passes input straight through
// - Count source sampled on Q2, Q4
// - One prescaler, counter or watchdog, exclusive
// - Rate field divides 1:2-1:256 or 1:1-1:128
// - Assignment bit zero counter, one watchdog
// - Counter write clears prescaler when assigned
module tsp_timer8 #(
    parameter int CNT_WIDTH = 8
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       ext_count_input,
    input  wire logic       sleep_mode,
    input  wire logic       wdt_tick,
    input  wire logic       wdt_clear,
    output logic            wdt_timeout,
    output logic            overflow_irq
);

    // Wider counters would need a wider bus
    // Only the documented 8-bit counter is supported
    generate
        if (CNT_WIDTH != 8) begin : g_bad_width
            $error("tsp_timer8 supports CNT_WIDTH of 8 only");
        end
    endgenerate

    // Free-running quarter phase counter:
    // one instruction cycle is four clocks.
    // Inhibit, sample points and timer source
    // are all timed against this counter.
    // One record keeps reset and next state
    // easy to compare field by field.
    // All state of the timer core in one record
    typedef struct packed {
        logic [1:0]           phase;     // Quarter phase Q1..Q4 as 0..3
        logic                 pin_meta;  // First synchroniser stage
        logic                 pin_sync;  // Second synchroniser stage
        logic                 samp;      // Count level at last Q2/Q4
        logic [1:0]           inhibit;   // Instruction cycles still held
        logic [CNT_WIDTH-1:0] count;     // count_reg
        logic [7:0]           int_ctrl;  // interrupt_control
        logic [7:0]           option;    // option_config
        logic [7:0]           rdata;     // Read data, one cycle late
        logic                 wdt_prev;  // Watchdog level one clock ago
        logic                 wdt_pulse; // Registered timeout pulse
    } tsp_state_t;

    tsp_state_t st_r;                    // Registered state
    tsp_state_t st_nxt;                  // Next state

    // Interface keeps mux and prescaler
    // agreed on names and directions
    tsp_psc_if  psc_if ();               // Link to the shared prescaler

    // All combinational decodes of the state and the inputs
    // Decoded controls
    logic                            clk_src_ext;  // Counter mode
    logic                            edge_fall;    // Count falling edges
    logic                            psc_to_wdt;   // Prescaler on watchdog
    logic [tsp_pkg::RATE_W-1:0]      rate;         // prescale_rate
    logic                            instr_end;    // Last quarter phase
    logic                            sample_pt;    // Q2 or Q4
    logic                            wr_count;     // Write to count_reg
    logic                            wr_int;       // Write to int_ctrl
    logic                            wr_opt;       // Write to option
    logic                            cnt_src;      // Undivided count level
    logic                            cnt_level;    // Level seen by sampler
    logic                            wdt_level;    // Level for timeout
    logic                            count_inc;    // Counter advances now

    // Mode change acts one clock after write
    // Field decode from option_config
    assign clk_src_ext = st_r.option[tsp_pkg::OPT_CLK_SRC];
    assign edge_fall   = st_r.option[tsp_pkg::OPT_EDGE_SEL];
    assign psc_to_wdt  = st_r.option[tsp_pkg::OPT_PSC_ASGN];
    assign rate        = st_r.option[tsp_pkg::OPT_RATE_LO +:
                                     tsp_pkg::RATE_W];

    // Q1..Q4 are phase 0..3; Q4 ends a cycle
    // Quarter phase decode; one ref_clk per quarter phase
    assign instr_end = (st_r.phase == tsp_pkg::PHASE_Q4);
    assign sample_pt = (st_r.phase == tsp_pkg::PHASE_Q2) ||
                       (st_r.phase == tsp_pkg::PHASE_Q4);

    // Single-cycle strobes, effect next edge
    // Mirror saves software a page switch
    // Write decode; interrupt_control answers at both of its addresses
    assign wr_count = reg_wr && (reg_addr == tsp_pkg::ADDR_COUNT);
    assign wr_int   = reg_wr && ((reg_addr == tsp_pkg::ADDR_INT_CTRL) ||
                                 (reg_addr == tsp_pkg::ADDR_INT_CTRL_B));
    assign wr_opt   = reg_wr && (reg_addr == tsp_pkg::ADDR_OPTION);

    // Both modes hand a level, not a pulse,
    // so one rise detector style serves all
    // Undivided count source. Timer mode uses a level that is high in
    // Q3 and Q4, so it rises once per instruction cycle. Counter mode
    // inverts the synchronised pin for falling edges, so a rise always
    // marks the chosen edge. Flipping the edge bit can fake one edge.
    always_comb begin
        if (clk_src_ext) begin
            cnt_src = st_r.pin_sync ^ edge_fall;
        end else begin
            cnt_src = st_r.phase[tsp_pkg::PHASE_INSTR_BIT];
        end
    end

    // Only one owner of the prescaler.
    // The other side sees its raw source:
    // watchdog at base rate, or counter
    // counting every event undivided.
    // Switching owner leaves a stale count;
    // one false rise may follow.
    // Prescaler routing: it serves exactly one user at a time
    always_comb begin
        if (psc_to_wdt) begin
            psc_if.src_level = wdt_tick;
            // watchdog divides 1:1 up to 1:128
            psc_if.div_log2  = {1'b0, rate};
            psc_if.clear     = wdt_clear;
            cnt_level        = cnt_src;
            wdt_level        = psc_if.out_level;
        end else begin
            psc_if.src_level = cnt_src;
            // counter divides 1:2 up to 1:256
            psc_if.div_log2  = {1'b0, rate} + tsp_pkg::DIV_ONE;
            psc_if.clear     = wr_count;
            cnt_level        = psc_if.out_level;
            wdt_level        = wdt_tick;
        end
    end

    // Edges seen only at two sample points.
    // Pulses under two clocks high or low
    // can slip between them and be lost;
    // the price of a synchronous counter.
    // Holds come after the edge test, so the
    // sampler history still advances.
    // Increment on a rise of the divided level seen at Q2/Q4, unless a
    // write is pending, the inhibit window runs, or the core sleeps
    always_comb begin
        // Default: rise seen at a sample point
        // rise between two sample points
        count_inc = sample_pt && cnt_level && !st_r.samp;
        if (st_r.inhibit != 2'h0) begin
            count_inc = 1'b0;
        end
        if (sleep_mode) begin
            count_inc = 1'b0;
        end
        // A software write in the same cycle takes the counter
        if (wr_count) begin
            count_inc = 1'b0;
        end
    end

    // One process computes all next state;
    // the register process only copies it
    // Next-state logic of the whole core
    always_comb begin
        st_nxt = st_r;

        // Unnamed fields hold; no latches
        // Free-running quarter phase divider
        st_nxt.phase = st_r.phase + 2'h1;

        // Pin is asynchronous; first stage
        // may go metastable, so never read it
        // Two-stage synchroniser on the pin; only the second is read
        st_nxt.pin_meta = ext_count_input;
        st_nxt.pin_sync = st_r.pin_meta;

        // Updated even while held: an edge in a
        // hold is dropped, not delayed
        // Sampler keeps the level seen at the last Q2/Q4
        if (sample_pt) begin
            st_nxt.samp = cnt_level;
        end

        // Write arms two; each later Q4 takes one.
        // A write on a Q4 edge still holds two
        // full cycle ends, never fewer.
        // A new write restarts the window.
        // Inhibit window counts down at each instruction cycle end
        if (wr_count) begin
            st_nxt.inhibit = tsp_pkg::INHIBIT_CYCLES;
        end else if (instr_end && (st_r.inhibit != 2'h0)) begin
            st_nxt.inhibit = st_r.inhibit - 2'h1;
        end

        // Write beats increment, so a value read
        // straight back is never off by one
        // Counter register
        if (wr_count) begin
            st_nxt.count = reg_wdata[CNT_WIDTH-1:0];
        end else if (count_inc) begin
            st_nxt.count = st_r.count + 1'b1;
        end

        // Unused bits kept too, so reads return
        // exactly what software wrote
        // Option register, plain storage
        if (wr_opt) begin
            st_nxt.option = reg_wdata;
        end

        // All eight bits stored; bits of other
        // sources are kept but not acted on.
        // Overflow set applied after the write,
        // so an overflow meeting a clear stays.
        // Interrupt control: software writes every bit first
        if (wr_int) begin
            st_nxt.int_ctrl = reg_wdata;
        end
        // wrap sets overflow flag, set beats a clear
        if (count_inc && (st_r.count == tsp_pkg::COUNT_MAX)) begin
            st_nxt.int_ctrl[tsp_pkg::INT_OVF_FLAG] = 1'b1;
        end

        // One pulse per divided rise of tick.
        // A level that rose under the other
        // owner may give one early pulse.
        // Watchdog timeout as a one-clock pulse on each rise
        st_nxt.wdt_prev  = wdt_level;
        st_nxt.wdt_pulse = wdt_level && !st_r.wdt_prev;

        // Registered; stands one cycle only.
        // A late reader sees zero, not stale data
        // Read data for the cycle after the read strobe
        st_nxt.rdata = tsp_pkg::RDATA_NONE;
        if (reg_rd) begin
            case (reg_addr)
                tsp_pkg::ADDR_COUNT: begin
                    st_nxt.rdata = st_r.count;
                end
                tsp_pkg::ADDR_INT_CTRL,
                tsp_pkg::ADDR_INT_CTRL_B: begin
                    st_nxt.rdata = st_r.int_ctrl;
                end
                tsp_pkg::ADDR_OPTION: begin
                    st_nxt.rdata = st_r.option;
                end
                default: begin
                    // Unmapped addresses read as zero
                    st_nxt.rdata = tsp_pkg::RDATA_NONE;
                end
            endcase
        end
    end

    // Constants only, field by field, so no
    // next state leaks through during reset.
    // Option comes up all ones: counter mode,
    // falling edge, prescaler on watchdog at
    // its slowest rate. Program before use.
    // State register with synchronous reset to constants only
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r.phase     <= 2'h0;
            st_r.pin_meta  <= 1'b0;
            st_r.pin_sync  <= 1'b0;
            st_r.samp      <= 1'b0;
            st_r.inhibit   <= 2'h0;
            st_r.count     <= tsp_pkg::RST_COUNT;
            st_r.int_ctrl  <= tsp_pkg::RST_INT_CTRL;
            st_r.option    <= tsp_pkg::RST_OPTION;
            st_r.rdata     <= tsp_pkg::RDATA_NONE;
            st_r.wdt_prev  <= 1'b0;
            st_r.wdt_pulse <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Hidden count, no software access;
    // cleared only by reset or through the routing above
    // Shared prescaler instance
    tsp_prescaler #(
        .PSC_WIDTH (8)
    ) u_prescaler (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .bus     (psc_if.psc)
    );

    // Data outputs leave from flip-flops.
    // Interrupt is an AND of two register
    // bits: follows a write next cycle.
    // Sleep never masks the flag itself.
    // Outputs
    assign reg_rdata   = st_r.rdata;
    assign wdt_timeout = st_r.wdt_pulse;
    assign overflow_irq = st_r.int_ctrl[tsp_pkg::INT_OVF_FLAG] &&
                          st_r.int_ctrl[tsp_pkg::INT_OVF_EN];

endmodule
`default_nettype wire

// File: rtl/tsp_pkg.sv
// Package of register map, field positions and timing constants for timer8
package tsp_pkg;

    // Register byte addresses on the plain register port
    localparam logic [7:0] ADDR_COUNT      = 8'h01;
    localparam logic [7:0] ADDR_INT_CTRL   = 8'h0b;
    localparam logic [7:0] ADDR_INT_CTRL_B = 8'h8b;
    localparam logic [7:0] ADDR_OPTION     = 8'h81;

    // Reset values
    localparam logic [7:0] RST_INT_CTRL = 8'h00;
    localparam logic [7:0] RST_OPTION   = 8'hff;
    localparam logic [7:0] RST_COUNT    = 8'h00;
    localparam logic [7:0] RDATA_NONE   = 8'h00;

    // Field positions in option_config
    localparam int OPT_CLK_SRC   = 5;
    localparam int OPT_EDGE_SEL  = 4;
    localparam int OPT_PSC_ASGN  = 3;
    localparam int OPT_RATE_LO   = 0;
    localparam int RATE_W        = 3;

    // Field positions in interrupt_control
    localparam int INT_OVF_EN    = 5;
    localparam int INT_OVF_FLAG  = 2;

    // Counter wrap value
    localparam logic [7:0] COUNT_MAX = 8'hff;

    // Quarter phases of one instruction cycle, one ref_clk each
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    localparam int         PHASE_INSTR_BIT = 1;

    // Instruction cycles of increment inhibit after a counter write
    localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

    // Prescaler divide exponent width (0..8)
    localparam int DIV_W = 4;
    localparam logic [3:0] DIV_ONE = 4'h1;

endpackage

// File: rtl/tsp_psc_if.sv
// Interface between the timer core and the shared prescaler
`timescale 1ns/1ns
`default_nettype none
interface tsp_psc_if;
    logic                          src_level; // Level whose rises are counted
    logic                          clear;     // Clear prescaler count
    logic [tsp_pkg::DIV_W-1:0]     div_log2;  // Divide by 2**div_log2
    logic                          out_level; // Divided level

    modport ctl (
        output src_level,
        output clear,
        output div_log2,
        input  out_level
    );
    modport psc (
        input  src_level,
        input  clear,
        input  div_log2,
        output out_level
    );
endinterface
`default_nettype wire

// File: rtl/tsp_prescaler.sv
// Shared 8-bit prescaler counting rising edges of a source level
`timescale 1ns/1ns
`default_nettype none
module tsp_prescaler #(
    parameter int PSC_WIDTH = 8
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    tsp_psc_if.psc    bus
);

    // Refuse widths the divide select cannot address
    generate
        if (PSC_WIDTH != 8) begin : g_bad_width
            $error("tsp_prescaler supports PSC_WIDTH of 8 only");
        end
    endgenerate

    // All state of the prescaler
    typedef struct packed {
        logic [PSC_WIDTH-1:0] cnt;      // Hidden divide count
        logic                 src_prev; // Source level one clock ago
    } tsp_psc_state_t;

    tsp_psc_state_t st_r;
    tsp_psc_state_t st_nxt;
    logic [tsp_pkg::DIV_W-1:0] tap;     // Count bit that forms the output

    // Next state: count rises of the source, clear wins over a count
    always_comb begin
        st_nxt = st_r;
        st_nxt.src_prev = bus.src_level;
        if (bus.clear) begin
            st_nxt.cnt = '0;
        end else if (bus.src_level && !st_r.src_prev) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    // Registered state, synchronous reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Output tap: divide by one passes the source straight through
    assign tap = bus.div_log2 - tsp_pkg::DIV_ONE;
    assign bus.out_level = (bus.div_log2 == '0) ? bus.src_level
                                               : st_r.cnt[tap[2:0]];

endmodule
`default_nettype wire

// File: testbench/tsp_timer8_monitor.sv
// Port checker for the timer8 block, bound to its top
`timescale 1ns/1ns
`default_nettype none
module tsp_timer8_monitor #(
    parameter int CNT_WIDTH = 8
) (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       ext_count_input,
    input wire logic       sleep_mode,
    input wire logic       wdt_tick,
    input wire logic       wdt_clear,
    input wire logic       wdt_timeout,
    input wire logic       overflow_irq
);
    // One clock domain, reset masks every check
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read");
    property p_opt_rw;
        reg_wr && reg_addr == tsp_pkg::ADDR_OPTION ##1 reg_rd &&
        reg_addr == tsp_pkg::ADDR_OPTION |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_opt_rw: assert property (p_opt_rw)
        else $error("option read back differs from write");
    property p_cnt_inh;
        reg_wr && reg_addr == tsp_pkg::ADDR_COUNT ##1 reg_rd &&
        reg_addr == tsp_pkg::ADDR_COUNT |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_cnt_inh: assert property (p_cnt_inh)
        else $error("count moved right after a write");
    property p_irq_mask;
        reg_wr && reg_addr == tsp_pkg::ADDR_INT_CTRL &&
        !reg_wdata[tsp_pkg::INT_OVF_EN] |=> !overflow_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt seen with enable cleared");
    property p_flag_hold; overflow_irq && !reg_wr |=> overflow_irq; endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("interrupt dropped without software write");
    property p_sleep;
        sleep_mode && $past(sleep_mode) && !$past(reg_wr)
        |-> !$rose(overflow_irq);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("overflow raised while asleep");
    property p_wdt_pulse; wdt_timeout |=> !wdt_timeout; endproperty
    a_wdt_pulse: assert property (p_wdt_pulse)
        else $error("watchdog timeout longer than one cycle");
    property p_wdt_cause;
        $rose(wdt_timeout) |-> $past(wdt_tick) || $past(wdt_tick, 2);
    endproperty
    a_wdt_cause: assert property (p_wdt_cause)
        else $error("watchdog timeout without a tick");
endmodule

bind tsp_timer8 tsp_timer8_monitor #(.CNT_WIDTH(CNT_WIDTH)) i_mon (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_count_input(ext_count_input),
    .sleep_mode(sleep_mode), .wdt_tick(wdt_tick), .wdt_clear(wdt_clear),
    .wdt_timeout(wdt_timeout), .overflow_irq(overflow_irq)
);
`default_nettype wire

// File: testbench/tsp_ext_src.sv
// Model of the external clock source on the count pin
`timescale 1ns/1ns
`default_nettype none
module tsp_ext_src #(
    parameter int HOLD = 3 // Clocks per level; raise to run slow
) (
    input  wire logic ref_clk,
    output logic      pin
);
    // Pin rests low between bursts
    initial pin = 1'b0;
    task automatic level(input logic l);
        repeat (HOLD) @(posedge ref_clk);
        pin <= l;
    endtask
    // Whole pulses only, so the pin ends low
    task automatic burst(input int n);
        repeat (n) begin
            level(1'b1);
            level(1'b0);
        end
    endtask
endmodule
`default_nettype wire

// File: testbench/tsp_timer8_tb.sv
// Self-checking bench for the timer8 block
`timescale 1ns/1ns
`default_nettype none
module tsp_timer8_tb;
    logic       ref_clk;      // 100 MHz clock
    logic       rst_n;        // Synchronous reset
    logic [7:0] reg_addr;     // Register address
    logic [7:0] reg_wdata;    // Write data
    logic       reg_wr;       // Write strobe
    logic       reg_rd;       // Read strobe
    logic [7:0] reg_rdata;    // Read data
    logic       ext_pin;      // Count pin from the source model
    logic       sleep_mode;   // Sleep level
    logic       wdt_tick;     // Raw watchdog tick
    logic       wdt_clear;    // Watchdog clear pulse
    logic       wdt_timeout;  // Postscaled timeout
    logic       overflow_irq; // Masked overflow
    int         bad_count;    // Mismatches
    int         comparisons;  // Checks made
    int         wdt_seen;     // Timeout pulses tallied

    tsp_timer8 i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_count_input(ext_pin),
        .sleep_mode(sleep_mode), .wdt_tick(wdt_tick), .wdt_clear(wdt_clear),
        .wdt_timeout(wdt_timeout), .overflow_irq(overflow_irq)
    );
    tsp_ext_src i_src (.ref_clk(ref_clk), .pin(ext_pin));

    // Free running clock
    always #5 ref_clk = ~ref_clk;
    // Tally timeouts; a pulse stands one cycle only
    always @(posedge ref_clk) begin
        if (wdt_timeout === 1'b1)
            wdt_seen++;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Write then read back at once, or read alone
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= ~w;
        if (w) begin
            @(posedge ref_clk);
            reg_wr <= 1'b0;
            reg_rd <= 1'b1;
        end
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Count advance between two reads n clocks apart
    task automatic meas(input int n, output logic [7:0] dv);
        logic [7:0] v1;
        logic [7:0] v2;
        xfer(1'b0, tsp_pkg::ADDR_COUNT, 8'h00, v1);
        repeat (n - 2) @(posedge ref_clk);
        xfer(1'b0, tsp_pkg::ADDR_COUNT, 8'h00, v2);
        dv = v2 - v1;
    endtask

    task automatic t_regs;
        logic [7:0] v;
        logic [7:0] ad [5] = '{tsp_pkg::ADDR_COUNT, tsp_pkg::ADDR_OPTION,
            tsp_pkg::ADDR_INT_CTRL, tsp_pkg::ADDR_INT_CTRL_B, 8'h05};
        logic [7:0] ex [5] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
        foreach (ad[i]) begin
            xfer(1'b0, ad[i], 8'h00, v);
            check(v, ex[i]);
        end
        xfer(1'b1, tsp_pkg::ADDR_OPTION, 8'h5a, v);
        check(v, 8'h5a);
        xfer(1'b1, tsp_pkg::ADDR_COUNT, 8'h3c, v);
        check(v, 8'h3c);
        // Unmapped place keeps nothing
        xfer(1'b1, 8'h05, 8'h77, v);
        check(v, 8'h00);
        $display("Test registers finished");
    endtask

    task automatic t_rates;
        logic [7:0] v;
        logic [7:0] dv;
        xfer(1'b1, tsp_pkg::ADDR_OPTION, 8'h08, v);
        meas(40, dv);
        check(dv, 8'h0a);
        // Four increments at every prescale code
        for (int r = 0; r < 8; r++) begin
            xfer(1'b1, tsp_pkg::ADDR_OPTION, 8'(r), v);
            meas(16 << (r + 1), dv);
            check(dv, 8'h04);
        end
        $display("Test rates finished");
    endtask

    task automatic t_ovf;
        logic [7:0] v;
        xfer(1'b1, tsp_pkg::ADDR_OPTION, 8'h08, v);
        xfer(1'b1, tsp_pkg::ADDR_INT_CTRL, 8'h00, v);
        xfer(1'b1, tsp_pkg::ADDR_COUNT, 8'hfe, v);
        repeat (40) @(posedge ref_clk);
        xfer(1'b0, tsp_pkg::ADDR_INT_CTRL, 8'h00, v);
        check(v, 8'h04);
        check({7'h00, overflow_irq}, 8'h00);
        xfer(1'b1, tsp_pkg::ADDR_INT_CTRL_B, 8'h24, v);
        repeat (40) @(posedge ref_clk);
        check({7'h00, overflow_irq}, 8'h01);
        xfer(1'b1, tsp_pkg::ADDR_INT_CTRL, 8'h20, v);
        check(v, 8'h20);
        check({7'h00, overflow_irq}, 8'h00);
        // Frozen two counts short of overflow while asleep
        xfer(1'b1, tsp_pkg::ADDR_COUNT, 8'hfe, v);
        @(posedge ref_clk);
        sleep_mode <= 1'b1;
        repeat (100) @(posedge ref_clk);
        xfer(1'b0, tsp_pkg::ADDR_COUNT, 8'h00, v);
        check(v, 8'hfe);
        @(posedge ref_clk);
        sleep_mode <= 1'b0;
        repeat (40) @(posedge ref_clk);
        check({7'h00, overflow_irq}, 8'h01);
        xfer(1'b1, tsp_pkg::ADDR_INT_CTRL, 8'h00, v);
        $display("Test overflow finished");
    endtask

    task automatic t_ext;
        logic [7:0] v;
        logic [7:0] v1;
        for (int e = 0; e < 2; e++) begin
            xfer(1'b1, tsp_pkg::ADDR_OPTION, 8'h28 | 8'(e << 4), v);
            repeat (8) @(posedge ref_clk);
            xfer(1'b0, tsp_pkg::ADDR_COUNT, 8'h00, v1);
            i_src.level(1'b1);
            repeat (8) @(posedge ref_clk);
            xfer(1'b0, tsp_pkg::ADDR_COUNT, 8'h00, v);
            check(v - v1, 8'(1 - e));
            i_src.level(1'b0);
            i_src.burst(4);
            repeat (8) @(posedge ref_clk);
            xfer(1'b0, tsp_pkg::ADDR_COUNT, 8'h00, v);
            check(v - v1, 8'h05);
        end
        // Count write aligns the divide by two
        xfer(1'b1, tsp_pkg::ADDR_OPTION, 8'h20, v);
        repeat (8) @(posedge ref_clk);
        xfer(1'b1, tsp_pkg::ADDR_COUNT, 8'h00, v);
        // Let the inhibit window run out first
        repeat (12) @(posedge ref_clk);
        i_src.burst(10);
        repeat (8) @(posedge ref_clk);
        xfer(1'b0, tsp_pkg::ADDR_COUNT, 8'h00, v);
        check(v, 8'h05);
        $display("Test external finished");
    endtask

    task automatic t_wdt;
        logic [7:0] v;
        logic [7:0] op [3] = '{8'h08, 8'h0a, 8'h00};
        foreach (op[i]) begin
            xfer(1'b1, tsp_pkg::ADDR_OPTION, op[i], v);
            @(posedge ref_clk);
            wdt_clear <= 1'b1;
            @(posedge ref_clk);
            wdt_clear <= 1'b0;
            #1 wdt_seen = 0;
            // Sixteen tick rises, two clocks per level
            repeat (32) begin
                repeat (2) @(posedge ref_clk);
                wdt_tick <= ~wdt_tick;
            end
            repeat (8) @(posedge ref_clk);
            check(8'(wdt_seen), op[i][3] ? 8'h10 >> op[i][2:0] : 8'h10);
        end
        $display("Test watchdog finished");
    endtask

    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sleep_mode = 1'b0;
        wdt_tick = 1'b0;
        wdt_clear = 1'b0;
        bad_count = 0;
        comparisons = 0;
        wdt_seen = 0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_rates();
        t_ovf();
        t_ext();
        t_wdt();
        stop_test();
    end
endmodule
`default_nettype wire
